// [pp_defines.svh]
// register offsets, field positions and reset values of the parameter pipeline
`ifndef PP_DEFINES_SVH
`define PP_DEFINES_SVH

`define PP_ADDR_W            7
`define PP_OFS_GLOBAL_CONF   7'h00
`define PP_OFS_START_CONFIGURATION    7'h02
`define PP_OFS_GEARING       7'h12
`define PP_OFS_POS_COMPARE   7'h32
`define PP_OFS_TARGET        7'h37
`define PP_OFS_STAGE_FIRST   7'h38
`define PP_OFS_STAGE_LAST    7'h3F

`define PP_EN_LSB            24
`define PP_EN_MSB            27
`define PP_WB_LSB            8
`define PP_WB_MSB            15

`define PP_RST_WORD          32'h0000_0000
`define PP_RD_UNMAPPED       32'h0000_0000

`endif

// [pp_pkg.sv]
// types shared by the parameter pipeline
package pp_pkg;

	typedef enum logic [1:0]
	{
		PP_DST_TARGET  = 2'b00,
		PP_DST_COMPARE = 2'b01,
		PP_DST_GEARING = 2'b10,
		PP_DST_GLOBAL  = 2'b11
	} pp_dest_t;

	typedef logic [31:0] pp_word_t;

	typedef struct packed
	{
		logic [7:0][31:0] stage;
		logic [3:0][31:0] dest;
		logic [31:0]      start_configuration;
		logic [31:0]      rd_data;
	} pp_state_t;

endpackage

// [pp_parameter_pipeline.sv]
// parameter pipeline: eight stage registers split into up to four segments feeding live parameters
//
// Overview of operation
// - each start shifts all enabled segments together
// - target position loads stage zero when enabled
// - stages shift one place toward segment head
// - enable bit0 target, bit1 position compare
// - enable bit2 gearing, bit3 global configuration
// - eight writable stages, at most four segments
// - segments feed only the four destinations
// - all sixteen enables legal, depths 8/4/3-3-2/2
// - compare plus gearing: heads stage0, stage4
// - target, compare, gearing: heads 0, 3, 6
// - write-back bit copies live value into stage
// - write-back takes the segment owner's live value
`include "pp_defines.svh"

module pp_parameter_pipeline
(
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// internal start signal
	input  wire logic                  start_pulse,
	// register port
	input  wire logic                  reg_wr_en,
	input  wire logic                  reg_rd_en,
	input  wire logic [6:0]            reg_addr,
	input  wire pp_pkg::pp_word_t      reg_wr_data,
	output logic      [31:0]           reg_rd_data,
	// live parameters
	output logic      [31:0]           target_position,
	output logic      [31:0]           position_compare_value,
	output logic      [31:0]           gearing_factor,
	output logic      [31:0]           global_configuration
);
	import pp_pkg::*;

	pp_state_t r;
	pp_state_t next_r;

	////////////////////////////////////////////////////////////////////////////////
	// segment geometry

	// first stage of segment slot s when cnt segments exist
	function automatic logic [2:0] pp_head(input logic [2:0] slot, input logic [2:0] cnt);
		logic [5:0] h;
		h = 6'd0;
		case (cnt)
			3'd2:    h = {3'd0, slot} * 6'd4;
			3'd3:    h = {3'd0, slot} * 6'd3;
			3'd4:    h = {3'd0, slot} * 6'd2;
			default: h = 6'd0;
		endcase
		return h[2:0];
	endfunction

	// segment slot that stage i belongs to
	function automatic logic [2:0] pp_slot_of(input logic [3:0] i, input logic [2:0] cnt);
		logic [2:0] s;
		s = 3'd0;
		case (cnt)
			3'd2:    s = {2'd0, i[2]};
			3'd3:    s = (i < 4'd3) ? 3'd0 : ((i < 4'd6) ? 3'd1 : 3'd2);
			3'd4:    s = {1'b0, i[2:1]};
			default: s = 3'd0;
		endcase
		return s;
	endfunction

	logic [3:0] pipe_en;
	logic [7:0] wb_sel;
	assign pipe_en = r.start_configuration[`PP_EN_MSB:`PP_EN_LSB];
	assign wb_sel  = r.start_configuration[`PP_WB_MSB:`PP_WB_LSB];

	logic [2:0]      seg_cnt;
	logic [3:0][2:0] dest_slot;
	logic [3:0][1:0] slot_dest;

	// slots are handed out in destination order, so segments stay contiguous
	always_comb
	begin
		seg_cnt   = 3'd0;
		dest_slot = '0;
		slot_dest = '0;
		for (int d = 0; d < 4; d++)
		begin
			dest_slot[d] = seg_cnt;
			if (pipe_en[d])
			begin
				slot_dest[seg_cnt[1:0]] = 2'(d);
				seg_cnt = seg_cnt + 3'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic do_cycle;
	assign do_cycle = start_pulse && (pipe_en != 4'h0);

	always_comb
	begin
		logic [2:0] s_i;
		logic [2:0] s_up;
		logic       top;
		s_i    = 3'd0;
		s_up   = 3'd0;
		top    = 1'b0;
		next_r = r;
		if (do_cycle)
		begin
			// destinations read old stage values, so shift and load are simultaneous
			for (int d = 0; d < 4; d++)
			begin
				if (pipe_en[d])
				begin
					next_r.dest[d] = r.stage[pp_head(dest_slot[d], seg_cnt)];
				end
			end
			for (int i = 0; i < 8; i++)
			begin
				s_i  = pp_slot_of(4'(i), seg_cnt);
				s_up = pp_slot_of(4'(i + 1), seg_cnt);
				top  = (i == 7) || (s_up != s_i);
				if (wb_sel[i])
				begin
					next_r.stage[i] = r.dest[slot_dest[s_i[1:0]]];
				end
				else if (!top)
				begin
					next_r.stage[i] = r.stage[3'(i + 1)];
				end
			end
		end
		// a software write lands after the pipeline move and overrides it
		if (reg_wr_en)
		begin
			case (reg_addr)
				`PP_OFS_GLOBAL_CONF: next_r.dest[PP_DST_GLOBAL]  = reg_wr_data;
				`PP_OFS_START_CONFIGURATION:  next_r.start_configuration           = reg_wr_data;
				`PP_OFS_GEARING:     next_r.dest[PP_DST_GEARING] = reg_wr_data;
				`PP_OFS_POS_COMPARE: next_r.dest[PP_DST_COMPARE] = reg_wr_data;
				`PP_OFS_TARGET:      next_r.dest[PP_DST_TARGET]  = reg_wr_data;
				default:
				begin
					if (reg_addr >= `PP_OFS_STAGE_FIRST && reg_addr <= `PP_OFS_STAGE_LAST)
					begin
						next_r.stage[reg_addr[2:0]] = reg_wr_data;
					end
				end
			endcase
		end
		if (reg_rd_en)
		begin
			case (reg_addr)
				`PP_OFS_GLOBAL_CONF: next_r.rd_data = r.dest[PP_DST_GLOBAL];
				`PP_OFS_START_CONFIGURATION:  next_r.rd_data = r.start_configuration;
				`PP_OFS_GEARING:     next_r.rd_data = r.dest[PP_DST_GEARING];
				`PP_OFS_POS_COMPARE: next_r.rd_data = r.dest[PP_DST_COMPARE];
				`PP_OFS_TARGET:      next_r.rd_data = r.dest[PP_DST_TARGET];
				default:
				begin
					if (reg_addr >= `PP_OFS_STAGE_FIRST && reg_addr <= `PP_OFS_STAGE_LAST)
					begin
						next_r.rd_data = r.stage[reg_addr[2:0]];
					end
					else
					begin
						next_r.rd_data = `PP_RD_UNMAPPED;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r.stage      <= {8{`PP_RST_WORD}};
			r.dest       <= {4{`PP_RST_WORD}};
			r.start_configuration <= `PP_RST_WORD;
			r.rd_data    <= `PP_RST_WORD;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign reg_rd_data            = r.rd_data;
	assign target_position        = r.dest[PP_DST_TARGET];
	assign position_compare_value = r.dest[PP_DST_COMPARE];
	assign gearing_factor         = r.dest[PP_DST_GEARING];
	assign global_configuration   = r.dest[PP_DST_GLOBAL];

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking pp_cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	logic quiet;
	assign quiet = !reg_wr_en;

	sequence s_cycle_en(logic [3:0] e);
		start_pulse && pipe_en == e && quiet;
	endsequence

	// a start that moves at least one segment, with no software write beside it
	sequence s_cycle_on;
		start_pulse && pipe_en != 4'h0 && quiet;
	endsequence

	sequence s_stage_write;
		reg_wr_en && reg_addr >= `PP_OFS_STAGE_FIRST && reg_addr <= `PP_OFS_STAGE_LAST;
	endsequence

	sequence s_stage_read;
		reg_rd_en && !reg_wr_en && reg_addr >= `PP_OFS_STAGE_FIRST && reg_addr <= `PP_OFS_STAGE_LAST;
	endsequence

	// two target-only starts on neighbouring edges, no write-back
	sequence s_two_target_starts;
		s_cycle_en(4'b0001) ##0 wb_sel == 8'h00 ##1 s_cycle_en(4'b0001) ##0 wb_sel == 8'h00;
	endsequence

	a_target_from_head: assert property (s_cycle_en(4'b0001) |=> target_position == $past(r.stage[0]))
		else $error("target did not take stage zero");
	a_shift_down: assert property (s_cycle_en(4'b0001) ##0 wb_sel == 8'h00 |=> r.stage[3] == $past(r.stage[4]))
		else $error("stage did not shift from its successor");
	a_compare_gear_map: assert property (s_cycle_en(4'b0110)
		|=> position_compare_value == $past(r.stage[0]) && gearing_factor == $past(r.stage[4]))
		else $error("two segment mapping wrong");
	a_three_seg_map: assert property (s_cycle_en(4'b0111)
		|=> target_position == $past(r.stage[0]) && position_compare_value == $past(r.stage[3])
			&& gearing_factor == $past(r.stage[6]))
		else $error("three segment mapping wrong");
	a_four_seg_global: assert property (s_cycle_en(4'b1111) |=> global_configuration == $past(r.stage[6]))
		else $error("global configuration not fed from stage six");
	a_writeback_four: assert property (s_cycle_en(4'b0001) ##0 wb_sel == 8'h10
		|=> r.stage[4] == $past(target_position))
		else $error("write-back into stage four missing");
	a_writeback_owner: assert property (s_cycle_en(4'b0110) ##0 wb_sel[5]
		|=> r.stage[5] == $past(gearing_factor))
		else $error("write-back took wrong owner value");
	a_top_keeps: assert property (s_cycle_en(4'b0011) ##0 !wb_sel[3] |=> r.stage[3] == $past(r.stage[3]))
		else $error("segment top crossed into next segment");
	a_zero_enable: assert property (start_pulse && pipe_en == 4'h0 && quiet |=> $stable(r.stage) && $stable(r.dest))
		else $error("disabled pipeline moved");
	a_disabled_dest: assert property (s_cycle_en(4'b0010) |=> $stable(target_position) ##0 $stable(gearing_factor))
		else $error("disabled destination changed");
	a_idle_hold: assert property ((!start_pulse && quiet) [*2] |=> $stable(r.stage))
		else $error("stage changed without cause");

	// register port
	a_stage_load: assert property (s_stage_write
		|=> r.stage[$past(reg_addr[2:0])] == $past(reg_wr_data))
		else $error("stage write did not land");
	a_stage_readback: assert property (s_stage_read
		|=> reg_rd_data == $past(r.stage[reg_addr[2:0]]))
		else $error("stage read returned wrong word");
	a_conf_write: assert property (reg_wr_en && reg_addr == `PP_OFS_START_CONFIGURATION
		|=> r.start_configuration == $past(reg_wr_data))
		else $error("start configuration write lost");
	a_target_write: assert property (reg_wr_en && reg_addr == `PP_OFS_TARGET
		|=> target_position == $past(reg_wr_data))
		else $error("target position write lost");

	// segment moves
	a_single_gear: assert property (s_cycle_en(4'b0100)
		|=> gearing_factor == $past(r.stage[0]))
		else $error("lone gearing segment not fed from stage zero");
	a_four_seg_heads: assert property (s_cycle_en(4'b1111)
		|=> target_position == $past(r.stage[0]) && position_compare_value == $past(r.stage[2])
			&& gearing_factor == $past(r.stage[4]))
		else $error("four segment heads wrong");
	a_four_seg_tops: assert property (s_cycle_en(4'b1111) ##0 wb_sel == 8'h00
		|=> r.stage[0] == $past(r.stage[1]) && r.stage[1] == $past(r.stage[1]))
		else $error("two stage segment shifted wrongly");
	a_three_seg_tops: assert property (s_cycle_en(4'b0111) ##0 wb_sel == 8'h00
		|=> r.stage[2] == $past(r.stage[2]) && r.stage[5] == $past(r.stage[5]))
		else $error("three segment tops did not hold");
	a_disabled_compare: assert property (s_cycle_en(4'b1101)
		|=> $stable(position_compare_value))
		else $error("disabled compare value changed");
	a_last_keeps: assert property (s_cycle_on ##0 !wb_sel[7]
		|=> r.stage[7] == $past(r.stage[7]))
		else $error("last stage changed without write-back");
	a_wb_global: assert property (s_cycle_en(4'b1111) ##0 wb_sel[7]
		|=> r.stage[7] == $past(global_configuration))
		else $error("global value not written back");
	// the second start must pick up what the first one moved into stage zero
	a_two_starts: assert property (s_two_target_starts
		|=> target_position == $past(r.stage[1], 2))
		else $error("second start did not advance the target pipeline");

endmodule

// [pp_parameter_pipeline_tb.sv]
// self-checking bench of the parameter pipeline
module pp_parameter_pipeline_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        rst_n;
	logic        start_pulse;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [6:0]  reg_addr;
	logic [31:0] reg_wr_data;
	logic [31:0] reg_rd_data;
	wire  [31:0] dq[4];
	logic [31:0] st[8];
	logic [31:0] dv[4];
	int          num_errors;
	int          checked;

	pp_parameter_pipeline dut_u
	(
		.clk_sys                (clk_sys),
		.rst_n                  (rst_n),
		.start_pulse            (start_pulse),
		.reg_wr_en              (reg_wr_en),
		.reg_rd_en              (reg_rd_en),
		.reg_addr               (reg_addr),
		.reg_wr_data            (reg_wr_data),
		.reg_rd_data            (reg_rd_data),
		.target_position        (dq[0]),
		.position_compare_value (dq[1]),
		.gearing_factor         (dq[2]),
		.global_configuration   (dq[3])
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr_en   <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1;
		chk(reg_rd_data, exp);
	endtask

	// loads distinct stage values, fires one start, then checks destinations and every stage
	task automatic run_cfg(input logic [3:0] en, input logic [7:0] wb);
		logic [31:0] so[8];
		logic [31:0] vo[4];
		int          own[8];
		int          n;
		int          k;
		int          h;
		n = $countones(en);
		k = 0;
		for (int i = 0; i < 8; i++)
		begin
			st[i] = 32'h5A00_0000 + {en, wb, 8'(i)};
			wr(7'h38 + 7'(i), st[i]);
		end
		wr(7'h02, {4'h0, en, 8'h00, wb, 8'h00});
		@(posedge clk_sys);
		start_pulse <= 1'b1;
		@(posedge clk_sys);
		start_pulse <= 1'b0;
		#1;
		so = st;
		vo = dv;
		for (int d = 0; d < 4; d++)
			if (en[d])
			begin
				h = (n == 1) ? 0 : (n == 2) ? 4 * k : (n == 3) ? 3 * k : 2 * k;
				for (int i = h; i < 8; i++)
					own[i] = d;
				dv[d] = so[h];
				k++;
			end
		for (int d = 0; d < 4; d++)
			chk(dq[d], dv[d]);
		for (int i = 0; i < 8; i++)
		begin
			// a segment top never pulls from its neighbour segment
			if (en != 4'h0)
				st[i] = wb[i] ? vo[own[i]] : (i == 7 || own[i + 1] != own[i]) ? so[i] : so[i + 1];
			rd(7'h38 + 7'(i), st[i]);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int d = 0; d < 4; d++)
			chk(dq[d], 32'h0000_0000);
		rd(7'h02, 32'h0000_0000);
	endtask

	task automatic t_regs();
		wr(7'h37, 32'h1234_5678);
		dv[0] = 32'h1234_5678;
		rd(7'h37, dv[0]);
		chk(dq[0], dv[0]);
		wr(7'h01, 32'hFFFF_FFFF);
		rd(7'h01, 32'h0000_0000);
		rd(7'h40, 32'h0000_0000);
		wr(7'h02, 32'h00A5_C3FF);
		rd(7'h02, 32'h00A5_C3FF);
	endtask

	task automatic t_all_en();
		for (int e = 0; e < 16; e++)
			run_cfg(4'(e), 8'h00);
	endtask

	task automatic t_wb();
		run_cfg(4'b0001, 8'h10);
		run_cfg(4'b0011, 8'h11);
		run_cfg(4'b0110, 8'h20);
		run_cfg(4'b0010, 8'h81);
		run_cfg(4'b1111, 8'hFF);
	endtask

	// a reset in mid-run clears every register and the live outputs
	task automatic t_mid_reset();
		wr(7'h38, 32'hDEAD_0038);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		dv = '{default: 32'h0000_0000};
		for (int d = 0; d < 4; d++)
			chk(dq[d], dv[d]);
		rd(7'h38, 32'h0000_0000);
		rd(7'h02, 32'h0000_0000);
	endtask

	// two starts on neighbouring edges move the target pipeline two places
	task automatic t_two_starts();
		for (int i = 0; i < 8; i++)
			wr(7'h38 + 7'(i), 32'hC0DE_0000 + 32'(i));
		wr(7'h02, 32'h0100_0000);
		@(posedge clk_sys);
		start_pulse <= 1'b1;
		repeat (2) @(posedge clk_sys);
		start_pulse <= 1'b0;
		#1;
		chk(dq[0], 32'hC0DE_0001);
		chk(dq[3], dv[3]);
		rd(7'h38, 32'hC0DE_0002);
		rd(7'h3E, 32'hC0DE_0007);
		rd(7'h3F, 32'hC0DE_0007);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		rst_n       = 1'b0;
		start_pulse = 1'b0;
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
		reg_addr    = 7'h00;
		reg_wr_data = 32'h0000_0000;
		num_errors  = 0;
		checked     = 0;
		dv          = '{default: 32'h0000_0000};
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_mid_reset();
		t_all_en();
		t_wb();
		t_two_starts();
		end_of_test();
	end

	// cuts a hang short instead of letting the run spin forever
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end
endmodule
